//--- design/supervisor_pkg.sv
// Purpose: Shared constants and types for the supply supervisor core
// Assumes: 125 MHz core clock, synchronous active-high reset
// Notes:   Long counts are also top-level parameters so simulation can shorten them
package supervisor_pkg;

  localparam int CLK_KHZ          = 125000;
  localparam int WDOG_TIMEOUT_MS  = 800;
  localparam int RESET_DELAY_MS   = 100;
  localparam int SEAL_MIN_MS      = 5;
  localparam int SEAL_MAX_MS      = 35;
  localparam int WDOG_PULSE_NS    = 100;

  // Nominal time-out sits inside the 0.48 s to 1.12 s window
  localparam int WDOG_TIMEOUT_CYC = WDOG_TIMEOUT_MS * CLK_KHZ;
  localparam int RESET_DELAY_CYC  = RESET_DELAY_MS * CLK_KHZ;
  // Least and longest times are exact whole-cycle products, no rounding
  localparam int SEAL_MIN_CYC     = SEAL_MIN_MS * CLK_KHZ;
  localparam int SEAL_MAX_CYC     = SEAL_MAX_MS * CLK_KHZ;
  localparam int WDOG_PULSE_CYC   = (WDOG_PULSE_NS * (CLK_KHZ / 1000) + 999) / 1000;
  localparam int NUDGE_NUM        = 7;
  localparam int NUDGE_DEN        = 8;

  localparam int CNT_W            = 32;

  localparam logic       RESET_N_RST   = 1'b0;
  localparam logic       PF_N_RST      = 1'b0;
  localparam logic       SEAL_RST      = 1'b0;
  localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    PH_SUPPLY_LOW,
    PH_DELAY,
    PH_RUN
  } phase_e;

  typedef struct packed {
    logic level;
    logic oe_n;
  } pin_drive_s;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             expire;
    logic             nudge;
  } wdog_state_s;

  typedef struct packed {
    phase_e           phase;
    logic [CNT_W-1:0] delay_cnt;
    logic [CNT_W-1:0] seal_cnt;
    logic             supply_last;
    logic             seal;
    logic             reset_n;
    logic             pf_n;
    logic             wdi_last;
    logic             battery_connect;
    pin_drive_s       wdi_drive;
  } core_state_s;

endpackage

//--- design/wdog_timer.sv
// Purpose: Watchdog interval counter with 7/8 nudge window and expiry pulse
// Assumes: restart_in wins over counting; counter only advances while run_in
// Notes:   expire_out is a one-cycle pulse; nudge_out is a level of PULSE_CYC cycles
`timescale 1ns/1ps
module wdog_timer #(
  parameter int TIMEOUT_CYC = supervisor_pkg::WDOG_TIMEOUT_CYC,
  parameter int PULSE_CYC   = supervisor_pkg::WDOG_PULSE_CYC
) (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic run_in,
  input  wire logic restart_in,
  output logic      expire_out,
  output logic      nudge_out
);

  localparam logic [supervisor_pkg::CNT_W-1:0] LAST =
    supervisor_pkg::CNT_W'(TIMEOUT_CYC - 1);
  localparam logic [supervisor_pkg::CNT_W-1:0] NUDGE_AT =
    supervisor_pkg::CNT_W'(TIMEOUT_CYC * supervisor_pkg::NUDGE_NUM
                           / supervisor_pkg::NUDGE_DEN);
  localparam logic [supervisor_pkg::CNT_W-1:0] NUDGE_END =
    supervisor_pkg::CNT_W'(TIMEOUT_CYC * supervisor_pkg::NUDGE_NUM
                           / supervisor_pkg::NUDGE_DEN + PULSE_CYC);

  supervisor_pkg::wdog_state_s st;
  supervisor_pkg::wdog_state_s next_st;

  always_comb begin
    next_st        = st;
    next_st.expire = 1'b0;
    if (restart_in || !run_in) begin
      next_st.count = supervisor_pkg::CNT_RST;                   // [RULE2]
    end else if (st.count == LAST) begin
      next_st.count  = supervisor_pkg::CNT_RST;
      next_st.expire = 1'b1;                                     // [RULE12]
    end else begin
      next_st.count = st.count + 1'b1;
    end
    // Nudge window opens at 7/8 of the period and lasts one minimum pulse
    next_st.nudge = run_in && !restart_in && (st.count >= NUDGE_AT)
                    && (st.count < NUDGE_END);                   // [RULE4]
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st.count  <= supervisor_pkg::CNT_RST;
      st.expire <= 1'b0;
      st.nudge  <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign expire_out = st.expire;
  assign nudge_out  = st.nudge;

endmodule

//--- design/supervisor_watchdog_powerfail_seal.sv
// Purpose: Digital core of a battery-backup supply supervisor
// Assumes: Analog comparators arrive as synchronous levels; supply_ok_in is the supply monitor
// Notes:   Switchover and analog thresholds live outside this block
// Function
// [RULE1] Host must toggle the service input faster than the watchdog time-out.
// [RULE2] Every rising or falling service-input transition restarts the watchdog timer.
// [RULE3] A floating service input retriggers internally, so the watchdog never times out.
// [RULE4] Internal drive holds service input low for 7/8 period, then pulses high.
// [RULE5] Host should keep the service input low and pulse it before 7/8.
// [RULE6] Power-fail flag goes low while the sense comparator reports below threshold.
// [RULE7] Flag returns high only above threshold plus hysteresis; holds in between.
// [RULE8] While sealed, the backup battery stays disconnected.
// [RULE9] Seal arms on battery, grounded flag, high sense and 5-35 ms supply pulse.
// [RULE10] Seal ends on the first rising edge of reset with supply present.
// [RULE11] Reset output is active low and actively driven both ways.
// [RULE12] Watchdog time-out lies in 0.48-1.12 s, nominal 0.8 s, from last restart.
// [RULE13] A time-out asserts reset for the reset delay, then releases and restarts.
`timescale 1ns/1ps
module supervisor_watchdog_powerfail_seal #(
  parameter int WDOG_TIMEOUT_CYC = supervisor_pkg::WDOG_TIMEOUT_CYC,
  parameter int RESET_DELAY_CYC  = supervisor_pkg::RESET_DELAY_CYC,
  parameter int SEAL_MIN_CYC     = supervisor_pkg::SEAL_MIN_CYC,
  parameter int SEAL_MAX_CYC     = supervisor_pkg::SEAL_MAX_CYC,
  parameter int WDOG_PULSE_CYC   = supervisor_pkg::WDOG_PULSE_CYC
) (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic supply_ok_in,
  input  wire logic battery_present_in,
  input  wire logic wdog_service_in,
  input  wire logic aux_sense_above_in,
  input  wire logic aux_sense_above_hyst_in,
  input  wire logic powerfail_flag_n_pin_in,
  output logic      reset_n_out,
  output logic      powerfail_flag_n_out,
  output logic      battery_connect_out,
  output logic      sealed_out,
  output logic      wdog_drive_out,
  output logic      wdog_drive_oe_n_out
);

  localparam logic [supervisor_pkg::CNT_W-1:0] DELAY_LAST =
    supervisor_pkg::CNT_W'(RESET_DELAY_CYC - 1);
  localparam logic [supervisor_pkg::CNT_W-1:0] SEAL_MIN =
    supervisor_pkg::CNT_W'(SEAL_MIN_CYC);
  localparam logic [supervisor_pkg::CNT_W-1:0] SEAL_MAX =
    supervisor_pkg::CNT_W'(SEAL_MAX_CYC);

  supervisor_pkg::core_state_s st;
  supervisor_pkg::core_state_s next_st;

  logic wd_expire;
  logic wd_nudge;
  logic wd_run;
  logic wd_restart;
  logic wdi_edge;
  logic floating_retrig;
  logic arm_cond;

  // Either edge direction counts the same
  assign wdi_edge = wdog_service_in ^ st.wdi_last;                   // [RULE2]
  // Pin following our own nudge means nobody else drives it
  assign floating_retrig = wd_nudge && wdog_service_in;              // [RULE3]
  assign wd_run     = (st.phase == supervisor_pkg::PH_RUN);
  assign wd_restart = wdi_edge || floating_retrig;                   // [RULE2] [RULE3]

  // Flag pin held low by the outside while we drive it high marks the arming strap
  assign arm_cond = battery_present_in && aux_sense_above_in
                    && st.pf_n && !powerfail_flag_n_pin_in;          // [RULE9]

  wdog_timer #(
    .TIMEOUT_CYC (WDOG_TIMEOUT_CYC),
    .PULSE_CYC   (WDOG_PULSE_CYC)
  ) u_wdog (
    .clk_in     (clk_in),
    .srst_in    (srst_in),
    .run_in     (wd_run),
    .restart_in (wd_restart),
    .expire_out (wd_expire),
    .nudge_out  (wd_nudge)
  );

  always_comb begin
    next_st             = st;
    next_st.wdi_last    = wdog_service_in;
    next_st.supply_last = supply_ok_in;

    // Comparator with latch between the two trip levels
    if (!aux_sense_above_in) begin
      next_st.pf_n = 1'b0;                                           // [RULE6]
    end else if (aux_sense_above_hyst_in) begin
      next_st.pf_n = 1'b1;                                           // [RULE7]
    end

    unique case (st.phase)
      supervisor_pkg::PH_SUPPLY_LOW: begin
        next_st.reset_n   = 1'b0;                                    // [RULE11]
        next_st.delay_cnt = supervisor_pkg::CNT_RST;
        if (supply_ok_in) begin
          next_st.phase = supervisor_pkg::PH_DELAY;
        end
      end
      supervisor_pkg::PH_DELAY: begin
        next_st.reset_n = 1'b0;                                      // [RULE13]
        if (!supply_ok_in) begin
          next_st.phase = supervisor_pkg::PH_SUPPLY_LOW;
        end else if (st.delay_cnt == DELAY_LAST) begin
          next_st.phase   = supervisor_pkg::PH_RUN;
          next_st.reset_n = 1'b1;                                    // [RULE11]
        end else begin
          next_st.delay_cnt = st.delay_cnt + 1'b1;
        end
      end
      supervisor_pkg::PH_RUN: begin
        next_st.reset_n = 1'b1;
        if (!supply_ok_in) begin
          next_st.phase   = supervisor_pkg::PH_SUPPLY_LOW;
          next_st.reset_n = 1'b0;
        end else if (wd_expire) begin
          // Timer restarts by itself since it only runs in this phase
          next_st.phase     = supervisor_pkg::PH_DELAY;              // [RULE13]
          next_st.delay_cnt = supervisor_pkg::CNT_RST;
          next_st.reset_n   = 1'b0;
        end
      end
    endcase

    // Seal arming: measure how long the supply stays with the strap present
    if (supply_ok_in && arm_cond) begin
      if (st.seal_cnt != SEAL_MAX) begin
        next_st.seal_cnt = st.seal_cnt + 1'b1;                       // [RULE9]
      end
    end else if (supply_ok_in) begin
      next_st.seal_cnt = supervisor_pkg::CNT_RST;
    end
    if (st.supply_last && !supply_ok_in) begin
      next_st.seal_cnt = supervisor_pkg::CNT_RST;
      if ((st.seal_cnt > SEAL_MIN) && (st.seal_cnt < SEAL_MAX)) begin
        next_st.seal = 1'b1;                                         // [RULE9]
      end
    end

    // Reset release with supply present ends the seal
    if (st.seal && !st.reset_n && next_st.reset_n && supply_ok_in) begin
      next_st.seal = 1'b0;                                           // [RULE10]
    end
    next_st.battery_connect = !next_st.seal;                         // [RULE8]

    // Weak keeper low, high only during the nudge window
    next_st.wdi_drive.level = wd_nudge;                              // [RULE4]
    next_st.wdi_drive.oe_n  = 1'b0;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st.phase           <= supervisor_pkg::PH_SUPPLY_LOW;
      st.delay_cnt       <= supervisor_pkg::CNT_RST;
      st.seal_cnt        <= supervisor_pkg::CNT_RST;
      st.supply_last     <= 1'b0;
      st.seal            <= supervisor_pkg::SEAL_RST;
      st.reset_n         <= supervisor_pkg::RESET_N_RST;
      st.pf_n            <= supervisor_pkg::PF_N_RST;
      st.wdi_last        <= 1'b0;
      st.battery_connect <= 1'b1;
      st.wdi_drive.level <= 1'b0;
      st.wdi_drive.oe_n  <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign reset_n_out          = st.reset_n;                          // [RULE11]
  assign powerfail_flag_n_out = st.pf_n;
  assign battery_connect_out  = st.battery_connect;
  assign sealed_out           = st.seal;
  assign wdog_drive_out       = st.wdi_drive.level;
  assign wdog_drive_oe_n_out  = st.wdi_drive.oe_n;

endmodule

//--- verif/supervisor_props.sv
// Purpose: Port assertions for the supervisor core
// Assumes: One clock, sync active-high reset
// Notes:   Counter bounds allow a few cycles of pipeline slack
`timescale 1ns/1ps
module supervisor_props #(
  parameter int WDOG_TIMEOUT_CYC = supervisor_pkg::WDOG_TIMEOUT_CYC,
  parameter int RESET_DELAY_CYC  = supervisor_pkg::RESET_DELAY_CYC
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic supply_ok_in,
  input wire logic battery_present_in,
  input wire logic wdog_service_in,
  input wire logic aux_sense_above_in,
  input wire logic aux_sense_above_hyst_in,
  input wire logic powerfail_flag_n_pin_in,
  input wire logic reset_n_out,
  input wire logic powerfail_flag_n_out,
  input wire logic battery_connect_out,
  input wire logic sealed_out,
  input wire logic wdog_drive_out,
  input wire logic wdog_drive_oe_n_out
);
  localparam int NUDGE = WDOG_TIMEOUT_CYC * 7 / 8;
  logic [31:0] idle;
  logic [31:0] low;
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // Cleared on srst so the first release never sees unknown counts
  always_ff @(posedge clk_in) begin
    idle <= (srst_in || !reset_n_out || wdog_service_in != $past(wdog_service_in)) ?
            32'h0 : idle + 32'h1;
    low  <= (srst_in || reset_n_out) ? 32'h0 : low + 32'h1;
  end
  sequence s_fall;
    supply_ok_in && $past(supply_ok_in) && $fell(reset_n_out);
  endsequence
  sequence s_held;
    !reset_n_out [*8];
  endsequence
  chk_pf_low: assert property (!aux_sense_above_in |=> !powerfail_flag_n_out)
    else $error("flag high below trip");
  chk_pf_high: assert property (aux_sense_above_hyst_in |=> powerfail_flag_n_out)
    else $error("flag low above hysteresis");
  chk_pf_hold: assert property (aux_sense_above_in && !aux_sense_above_hyst_in
    |=> $stable(powerfail_flag_n_out)) else $error("flag moved inside hysteresis");
  chk_seal_batt: assert property (sealed_out |-> !battery_connect_out)
    else $error("battery connected while sealed");
  chk_seal_exit: assert property ($rose(reset_n_out) && supply_ok_in |-> !sealed_out)
    else $error("seal kept past reset release");
  chk_rst_supply: assert property (!supply_ok_in |=> !reset_n_out)
    else $error("reset high without supply");
  chk_rst_held: assert property (s_fall |=> s_held)
    else $error("time-out reset too short");
  chk_rst_delay: assert property ($rose(reset_n_out) |-> low >= RESET_DELAY_CYC)
    else $error("reset released early");
  chk_wdog_max: assert property (reset_n_out |-> idle <= WDOG_TIMEOUT_CYC + 4)
    else $error("no time-out after idle period");
  chk_wdog_min: assert property (s_fall |-> idle + 32'h4 >= WDOG_TIMEOUT_CYC)
    else $error("time-out too early");
  chk_nudge_time: assert property ($rose(wdog_drive_out) |-> idle + 32'h4 >= NUDGE)
    else $error("nudge before seven eighths");
endmodule
bind supervisor_watchdog_powerfail_seal supervisor_props #(
  .WDOG_TIMEOUT_CYC(WDOG_TIMEOUT_CYC),
  .RESET_DELAY_CYC (RESET_DELAY_CYC)
) i_supervisor_props (.*);

//--- verif/host_model.sv
// Purpose: Host processor servicing the watchdog pin
// Assumes: period_in of zero parks the host drive low
// Notes:   Released pin follows the weak internal drive
`timescale 1ns/1ps
module host_model (
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        active_in,
  input  wire logic        pulse_mode_in,
  input  wire logic [15:0] period_in,
  input  wire logic        dev_drive_in,
  input  wire logic        dev_oe_n_in,
  output logic             pin_out
);
  logic [15:0] cnt;
  logic        lvl;
  always_ff @(posedge clk_in) begin
    cnt <= (srst_in || cnt + 16'h0001 >= period_in) ? 16'h0000 : cnt + 16'h0001;
    if (srst_in || period_in == 16'h0000) begin
      lvl <= 1'b0;
    end else if (pulse_mode_in) begin
      lvl <= (cnt < 16'h0002); // Low-high-low once a period
    end else if (cnt == 16'h0000) begin
      lvl <= ~lvl; // One transition a period, slow or prompt
    end
  end
  // Undriven pin must not look like a held level
  assign pin_out = active_in ? lvl : (!dev_oe_n_in ? dev_drive_in : ~lvl);
endmodule

//--- verif/tb.sv
// Purpose: Self-checking bench for the supervisor core
// Assumes: Shortened counts; host model on the service pin
// Notes:   Waits are bounded; timings allow a few cycles of latency
`timescale 1ns/1ps
module tb;
  localparam int TO = 800;
  localparam int RD = 100;
  logic        clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        supply_ok = 1'b0;
  logic        batt = 1'b0;
  logic        above = 1'b0;
  logic        hyst = 1'b0;
  logic        pf_pin = 1'b1;
  logic        host_on = 1'b1;
  logic        pulse_mode = 1'b0;
  logic [15:0] period = 16'h0000;
  logic        svc, rst_n, pf_n, batt_con, sealed, drv, drv_oe_n;
  int          miscompares = 0;
  int          comparisons = 0;
  initial forever #4 clk_in = ~clk_in;
  supervisor_watchdog_powerfail_seal #(.WDOG_TIMEOUT_CYC(TO), .RESET_DELAY_CYC(RD),
    .SEAL_MIN_CYC(20), .SEAL_MAX_CYC(60), .WDOG_PULSE_CYC(3))
  i_supervisor_watchdog_powerfail_seal (.clk_in(clk_in), .srst_in(srst_in),
    .supply_ok_in(supply_ok), .battery_present_in(batt), .wdog_service_in(svc),
    .aux_sense_above_in(above), .aux_sense_above_hyst_in(hyst),
    .powerfail_flag_n_pin_in(pf_pin), .reset_n_out(rst_n), .powerfail_flag_n_out(pf_n),
    .battery_connect_out(batt_con), .sealed_out(sealed), .wdog_drive_out(drv),
    .wdog_drive_oe_n_out(drv_oe_n));
  host_model i_host_model (.clk_in(clk_in), .srst_in(srst_in), .active_in(host_on),
    .pulse_mode_in(pulse_mode), .period_in(period), .dev_drive_in(drv),
    .dev_oe_n_in(drv_oe_n), .pin_out(svc));
  task automatic conclude();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_rst(input logic lvl, output int c);
    c = 0;
    while (rst_n !== lvl && c < 5000) begin
      @(posedge clk_in); #1;
      c++;
    end
    if (c >= 5000) begin
      miscompares++;
      conclude();
    end
  endtask
  task automatic run_check(input int k);
    int lows = 0;
    repeat (k) begin
      @(posedge clk_in); #1;
      if (rst_n !== 1'b1) lows++;
    end
    check(lows, 0);
  endtask
  task automatic t_power();
    int c;
    @(posedge clk_in);
    supply_ok <= 1'b1;
    wait_rst(1'b1, c);
    check(c >= RD && c <= RD + 3, 1);
    $display("test power done");
  endtask
  task automatic t_pf();
    logic [9:0] ah = 10'h0b8;
    logic [4:0] ex = 5'h0c;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_in);
      {above, hyst} <= ah[2*i+:2];
      repeat (2) @(posedge clk_in);
      #1;
      check(pf_n, ex[i]);
    end
    $display("test powerfail done");
  endtask
  task automatic t_service();
    @(posedge clk_in);
    period <= 16'h0258;
    run_check(3000);
    @(posedge clk_in);
    pulse_mode <= 1'b1;
    period <= 16'h028a;
    run_check(3000);
    @(posedge clk_in);
    host_on <= 1'b0;
    period <= 16'h0000;
    run_check(3000);
    $display("test service done");
  endtask
  task automatic t_timeout();
    int c = 0;
    int n = 0;
    int nud = 0;
    int lo;
    logic prev;
    @(posedge clk_in);
    host_on <= 1'b1;
    // One host pulse pins down the last restart, then the pin stays low past the time-out
    period  <= 16'h0fff;
    prev = svc;
    while (rst_n === 1'b1 && n < 2000) begin
      @(posedge clk_in); #1;
      n++;
      c = (svc !== prev) ? 0 : c + 1;
      prev = svc;
      if (drv === 1'b1 && nud == 0 && c > 8) nud = c;
    end
    if (rst_n === 1'b1) begin
      miscompares++;
      conclude();
    end
    check(nud >= TO * 7 / 8 - 3 && nud <= TO * 7 / 8 + 3, 1);
    check(c >= TO - 2 && c <= TO + 4, 1);
    wait_rst(1'b1, lo);
    check(lo >= RD && lo <= RD + 3, 1);
    $display("test timeout done");
  endtask
  task automatic t_seal();
    int c;
    int dur [3] = '{15, 40, 70};
    logic [2:0] ex = 3'h2;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_in);
      {above, hyst, batt, pf_pin, supply_ok} <= 5'h1c;
      repeat (4) @(posedge clk_in);
      supply_ok <= 1'b1;
      repeat (dur[i]) @(posedge clk_in);
      supply_ok <= 1'b0;
      repeat (3) @(posedge clk_in);
      #1;
      check({sealed, batt_con}, {ex[i], ~ex[i]});
      @(posedge clk_in);
      {pf_pin, supply_ok} <= 2'h3;
      wait_rst(1'b1, c);
      check(sealed, 1'b0);
    end
    $display("test seal done");
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    #1;
    check({rst_n, batt_con, sealed, drv_oe_n}, 4'h4);
    @(posedge clk_in);
    srst_in <= 1'b0;
    t_power();
    t_pf();
    t_service();
    t_timeout();
    t_seal();
    conclude();
  end
endmodule
